// >>> include/mvcr_regs.vh
// Offsets, field positions, reset values and timing of the capability bank
`ifndef MVCR_REGS_VH
`define MVCR_REGS_VH

// ==========================================================================
// Register byte offsets
`define MVCR_OFF_PM_PTR 8'h40
`define MVCR_OFF_MSG_CTRL 8'h4C
`define MVCR_OFF_MSG_ADDR_LO 8'h50
`define MVCR_OFF_MSG_ADDR_HI 8'h54
`define MVCR_OFF_MSG_DATA 8'h58
`define MVCR_OFF_PD_CMD 8'h5C
`define MVCR_OFF_PD_WORD 8'h60
`define MVCR_OFF_VENDOR 8'h64
`define MVCR_OFF_TEST0 8'h68
`define MVCR_OFF_IRQ_STATUS 8'hC0
`define MVCR_OFF_IRQ_MASK 8'hC4
`define MVCR_OFF_IRQ_REQ 8'hC8

// ==========================================================================
// Capability identifiers and pointers
`define MVCR_ID_MSG 8'h05
`define MVCR_ID_PD 8'h03
`define MVCR_ID_VENDOR 8'h09
`define MVCR_NEXT_VENDOR 8'h64
`define MVCR_NEXT_SUBSYS 8'hB0
`define MVCR_VENDOR_LEN 16'h0034
`define MVCR_PM_NEXT_DN 8'h4C
`define MVCR_PM_NEXT_UP 8'h5C

// ==========================================================================
// Field positions
`define MVCR_MSG_EN_BIT 16
`define MVCR_MSG_MME_LO 20
`define MVCR_MSG_64_BIT 23
`define MVCR_PD_ADDR_LO 18
`define MVCR_PD_FLAG_BIT 31
`define MVCR_EV_PD_DONE 0
`define MVCR_EV_MSG_SENT 1

// ==========================================================================
// Reset values
`define MVCR_RST_TEST0 32'h04001060
`define MVCR_RST_ZERO 32'h00000000

// ==========================================================================
// EEPROM timing: 200 MHz core clock
`define MVCR_CLK_MHZ 200
`define MVCR_EE_ACCESS_NS 100

`endif

// >>> rtl/mvcr_eeprom_engine.v
// Product-data table access engine toward the EEPROM word port
module mvcr_eeprom_engine #(
    parameter ADDR_W = 6
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // Command side
    input wire start_i,
    input wire write_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    output wire busy_o,
    output reg done_o,
    output reg [31:0] rdata_o,
    // EEPROM word port
    output reg ee_req_o,
    output reg ee_we_o,
    output reg [ADDR_W-1:0] ee_addr_o,
    output reg [31:0] ee_wdata_o,
    input wire ee_ack_i,
    input wire [31:0] ee_rdata_i
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [1:0] state_q;

    assign busy_o = state_q[1];

    // ======================================================================
    // Request held until the EEPROM side acknowledges
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            done_o <= 1'b0;
            rdata_o <= 32'h00000000;
            ee_req_o <= 1'b0;
            ee_we_o <= 1'b0;
            ee_addr_o <= {ADDR_W{1'b0}};
            ee_wdata_o <= 32'h00000000;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (start_i)
                    begin
                        state_q <= ST_WAIT;
                        ee_req_o <= 1'b1;
                        ee_we_o <= write_i;
                        ee_addr_o <= addr_i;
                        ee_wdata_o <= wdata_i;
                    end
                end
                ST_WAIT:
                begin
                    if (ee_ack_i)
                    begin
                        state_q <= ST_IDLE;
                        ee_req_o <= 1'b0;
                        done_o <= 1'b1;
                        if (!ee_we_o)
                            rdata_o <= ee_rdata_i;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// >>> rtl/mvcr_msg_sender.v
// Interrupt message write issuer toward the port's transmit path
module mvcr_msg_sender (
    // Clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // Request from the bank
    input wire req_i,
    input wire [31:0] addr_lo_i,
    input wire [31:0] addr_hi_i,
    input wire [15:0] data_i,
    output reg sent_o,
    // Memory write request
    output reg mw_valid_o,
    output reg [63:0] mw_addr_o,
    output reg mw_64_o,
    output reg [31:0] mw_data_o,
    input wire mw_ready_i
);

    // ======================================================================
    // One outstanding message write; later requests wait for it
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mw_valid_o <= 1'b0;
            mw_addr_o <= 64'h0000000000000000;
            mw_64_o <= 1'b0;
            mw_data_o <= 32'h00000000;
            sent_o <= 1'b0;
        end
        else
        begin
            sent_o <= 1'b0;
            if (mw_valid_o)
            begin
                if (mw_ready_i)
                begin
                    mw_valid_o <= 1'b0;
                    sent_o <= 1'b1;
                end
            end
            else if (req_i)
            begin
                mw_valid_o <= 1'b1;
                mw_addr_o <= {addr_hi_i, addr_lo_i[31:2], 2'b00};
                mw_64_o <= (addr_hi_i != 32'h00000000);
                mw_data_o <= {16'h0000, data_i};
            end
        end
    end

endmodule

// >>> rtl/mvcr_bank.v
// Message-interrupt, product-data and vendor capability register bank
//
// Functional notes
// - Message capability header reads identifier 05h
// - Both headers point next at 64h
// - Enable gates messages; legacy interrupt suppressed when set
// - 64-bit capable bit read-only, reads 1
// - Message address bits 31:2 writable, low zero
// - Upper address writable, used for 64-bit
// - Message structures only on downstream ports
// - Product-data header reads 03h, upstream only
// - Six-bit table dword address at 23:18
// - Flag 0 starts read, set when done
// - Flag 1 starts write, cleared when done
// - Data register returns last fetched dword
// - Written data is stored by write
// - Vendor header reads 09h, next B0h
// - Vendor length field reads 0034h
// - Test register resets 04001060h, no effect
// - Power pointer 4Ch downstream, 5Ch upstream
//
// The Wishbone register port is this design's own decision.
`include "mvcr_regs.vh"

module mvcr_bank #(
    parameter UPSTREAM = 0,
    parameter PD_ADDR_W = 6
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Port events
    input wire irq_event_i,
    output wire legacy_irq_o,
    output wire [7:0] pm_next_ptr_o,
    // Message memory write
    output wire mw_valid_o,
    output wire [63:0] mw_addr_o,
    output wire mw_64_o,
    output wire [31:0] mw_data_o,
    input wire mw_ready_i,
    // EEPROM word port
    output wire ee_req_o,
    output wire ee_we_o,
    output wire [PD_ADDR_W-1:0] ee_addr_o,
    output wire [31:0] ee_wdata_o,
    input wire ee_ack_i,
    input wire [31:0] ee_rdata_i,
    // Block interrupt
    output wire irq_o
);

    localparam HAS_MSG = (UPSTREAM == 0);
    localparam HAS_PD = (UPSTREAM != 0);

    // ======================================================================
    // State
    reg msg_en_q;
    reg [2:0] msg_mme_q;
    reg [29:0] msg_addr_lo_q;
    reg [31:0] msg_addr_hi_q;
    reg [15:0] msg_data_q;
    reg [PD_ADDR_W-1:0] pd_addr_q;
    reg pd_flag_q;
    reg [31:0] pd_wdata_q;
    reg pd_start_q;
    reg [31:0] test0_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;
    reg msg_pending_q;
    reg [31:0] rd_d;

    wire pd_busy;
    wire pd_done;
    wire [31:0] pd_rdata;
    wire msg_sent;
    wire wb_req;
    wire wr;
    wire [31:0] wmask;
    wire [31:0] wval_ctrl;
    wire [31:0] wm_ctrl;
    wire [31:0] wm_lo;
    wire [31:0] wm_data;
    wire [31:0] wm_irqm;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = wb_req && wb_we_i;

    // Byte-lane mask of a write
    function [31:0] lanes;
        input [3:0] sel;
        begin
            lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // Merge a write into an old value under byte lanes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] msk;
        begin
            merge = (old & ~msk) | (nw & msk);
        end
    endfunction

    assign wmask = lanes(wb_sel_i);

    // Current control word for merging writes at 4Ch or 5Ch
    assign wval_ctrl = HAS_MSG ?
        {9'h000, msg_mme_q, 3'h0, msg_en_q, 16'h0000} :
        {pd_flag_q, 7'h00, pd_addr_q, 18'h00000};

    // Write values merged under byte lanes, one per register shape
    assign wm_ctrl = merge(wval_ctrl, wb_dat_i, wmask);
    assign wm_lo = merge({msg_addr_lo_q, 2'b00}, wb_dat_i, wmask);
    assign wm_data = merge({16'h0000, msg_data_q}, wb_dat_i, wmask);
    assign wm_irqm = merge({30'h0, irq_mask_q}, wb_dat_i, wmask);

    assign pm_next_ptr_o = HAS_MSG ? `MVCR_PM_NEXT_DN :
                                     `MVCR_PM_NEXT_UP;

    // Legacy interrupt only while messages are disabled
    assign legacy_irq_o = irq_event_i && !msg_en_q;

    // ======================================================================
    // Register writes
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            msg_en_q <= 1'b0;
            msg_mme_q <= 3'h0;
            msg_addr_lo_q <= 30'h0;
            msg_addr_hi_q <= `MVCR_RST_ZERO;
            msg_data_q <= 16'h0000;
            pd_addr_q <= {PD_ADDR_W{1'b0}};
            pd_flag_q <= 1'b0;
            pd_wdata_q <= `MVCR_RST_ZERO;
            pd_start_q <= 1'b0;
            test0_q <= `MVCR_RST_TEST0;
            irq_mask_q <= 2'h0;
        end
        else
        begin
            pd_start_q <= 1'b0;
            // Engine completion flips the flag: read ends at 1, write at 0
            if (pd_done)
                pd_flag_q <= ~pd_flag_q;
            if (wr)
            begin
                if (wb_adr_i == `MVCR_OFF_MSG_CTRL && HAS_MSG)
                begin
                    msg_en_q <= wm_ctrl[`MVCR_MSG_EN_BIT];
                    msg_mme_q <= wm_ctrl[22:20];
                end
                else if (wb_adr_i == `MVCR_OFF_MSG_ADDR_LO && HAS_MSG)
                    msg_addr_lo_q <= wm_lo[31:2];
                else if (wb_adr_i == `MVCR_OFF_MSG_ADDR_HI && HAS_MSG)
                    msg_addr_hi_q <= merge(msg_addr_hi_q, wb_dat_i,
                                           wmask);
                else if (wb_adr_i == `MVCR_OFF_MSG_DATA && HAS_MSG)
                    msg_data_q <= wm_data[15:0];
                else if (wb_adr_i == `MVCR_OFF_PD_CMD && HAS_PD)
                begin
                    // A new command while busy is dropped; see polling
                    if (!pd_busy && wmask[31])
                    begin
                        pd_addr_q <=
                            wm_ctrl[`MVCR_PD_ADDR_LO +: PD_ADDR_W];
                        pd_flag_q <= wb_dat_i[`MVCR_PD_FLAG_BIT];
                        pd_start_q <= 1'b1;
                    end
                end
                else if (wb_adr_i == `MVCR_OFF_PD_WORD && HAS_PD)
                    pd_wdata_q <= merge(pd_wdata_q, wb_dat_i,
                                        wmask);
                else if (wb_adr_i == `MVCR_OFF_TEST0)
                    test0_q <= merge(test0_q, wb_dat_i, wmask);
                else if (wb_adr_i == `MVCR_OFF_IRQ_MASK)
                    irq_mask_q <= wm_irqm[1:0];
            end
        end
    end

    // ======================================================================
    // Message request and sticky status; set wins over clear
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            msg_pending_q <= 1'b0;
            irq_status_q <= 2'h0;
        end
        else
        begin
            if (msg_sent)
                msg_pending_q <= 1'b0;
            // Software or port event asks for a message while enabled
            if (HAS_MSG && msg_en_q && (irq_event_i ||
                (wr && wb_adr_i == `MVCR_OFF_IRQ_REQ && wb_dat_i[0])))
                msg_pending_q <= 1'b1;
            irq_status_q[`MVCR_EV_PD_DONE] <=
                pd_done || (irq_status_q[`MVCR_EV_PD_DONE] &&
                !(wr && wb_adr_i == `MVCR_OFF_IRQ_STATUS &&
                  wb_sel_i[0] && wb_dat_i[`MVCR_EV_PD_DONE]));
            irq_status_q[`MVCR_EV_MSG_SENT] <=
                msg_sent || (irq_status_q[`MVCR_EV_MSG_SENT] &&
                !(wr && wb_adr_i == `MVCR_OFF_IRQ_STATUS &&
                  wb_sel_i[0] && wb_dat_i[`MVCR_EV_MSG_SENT]));
        end
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

    // ======================================================================
    // Read mux; absent structures and unmapped offsets read zero
    always @*
    begin
        rd_d = 32'h00000000;
        if (wb_adr_i == `MVCR_OFF_MSG_CTRL && HAS_MSG)
            rd_d = {8'h00, 1'b1, msg_mme_q, 3'b000, msg_en_q,
                    `MVCR_NEXT_VENDOR, `MVCR_ID_MSG};
        else if (wb_adr_i == `MVCR_OFF_MSG_ADDR_LO && HAS_MSG)
            rd_d = {msg_addr_lo_q, 2'b00};
        else if (wb_adr_i == `MVCR_OFF_MSG_ADDR_HI && HAS_MSG)
            rd_d = msg_addr_hi_q;
        else if (wb_adr_i == `MVCR_OFF_MSG_DATA && HAS_MSG)
            rd_d = {16'h0000, msg_data_q};
        else if (wb_adr_i == `MVCR_OFF_PD_CMD && HAS_PD)
            rd_d = {pd_flag_q, 7'h00, pd_addr_q, 2'b00,
                    `MVCR_NEXT_VENDOR, `MVCR_ID_PD};
        else if (wb_adr_i == `MVCR_OFF_PD_WORD && HAS_PD)
            rd_d = pd_rdata;
        else if (wb_adr_i == `MVCR_OFF_VENDOR)
            rd_d = {`MVCR_VENDOR_LEN, `MVCR_NEXT_SUBSYS,
                    `MVCR_ID_VENDOR};
        else if (wb_adr_i == `MVCR_OFF_TEST0)
            rd_d = test0_q;
        else if (wb_adr_i == `MVCR_OFF_IRQ_STATUS)
            rd_d = {30'h0, irq_status_q};
        else if (wb_adr_i == `MVCR_OFF_IRQ_MASK)
            rd_d = {30'h0, irq_mask_q};
    end

    // ======================================================================
    // Bus answer: one registered ack per request, a cycle after it, dropped the next cycle
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
                wb_dat_o <= rd_d;
        end
    end

    // ======================================================================
    // Sub-blocks
    mvcr_eeprom_engine #(
        .ADDR_W(PD_ADDR_W)
    ) u_ee (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(pd_start_q),
        .write_i(pd_flag_q),
        .addr_i(pd_addr_q),
        .wdata_i(pd_wdata_q),
        .busy_o(pd_busy),
        .done_o(pd_done),
        .rdata_o(pd_rdata),
        .ee_req_o(ee_req_o),
        .ee_we_o(ee_we_o),
        .ee_addr_o(ee_addr_o),
        .ee_wdata_o(ee_wdata_o),
        .ee_ack_i(ee_ack_i),
        .ee_rdata_i(ee_rdata_i)
    );

    mvcr_msg_sender u_msg (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .req_i(msg_pending_q && !mw_valid_o && !msg_sent),
        .addr_lo_i({msg_addr_lo_q, 2'b00}),
        .addr_hi_i(msg_addr_hi_q),
        .data_i(msg_data_q),
        .sent_o(msg_sent),
        .mw_valid_o(mw_valid_o),
        .mw_addr_o(mw_addr_o),
        .mw_64_o(mw_64_o),
        .mw_data_o(mw_data_o),
        .mw_ready_i(mw_ready_i)
    );

endmodule

// >>> test/mvcr_bank_sva.sv
// Port-level assertions for the capability register bank
module mvcr_bank_sva #(
    parameter UPSTREAM = 0,
    parameter PD_ADDR_W = 6
) (
    // Clock and reset
    input logic ref_clk_i,
    input logic sys_rst_i,
    // Observed ports
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic irq_event_i,
    input logic legacy_irq_o,
    input logic [7:0] pm_next_ptr_o,
    input logic mw_valid_o,
    input logic [63:0] mw_addr_o,
    input logic mw_64_o,
    input logic [31:0] mw_data_o,
    input logic mw_ready_i,
    input logic ee_req_o,
    input logic ee_we_o,
    input logic [PD_ADDR_W-1:0] ee_addr_o,
    input logic ee_ack_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack not one cycle");
    chk_legacy_cause: assert property (
        legacy_irq_o |-> irq_event_i) else $error("legacy irq without event");
    chk_up_quiet: assert property (
        UPSTREAM != 0 |-> legacy_irq_o == irq_event_i && !mw_valid_o)
        else $error("message path active on upstream port");
    chk_dn_no_table: assert property (
        UPSTREAM == 0 |-> !ee_req_o) else $error("table access downstream");
    chk_pm_pointer: assert property (
        pm_next_ptr_o == ((UPSTREAM != 0) ? 8'h5C : 8'h4C))
        else $error("power pointer wrong");
    chk_msg_launch: assert property (
        irq_event_i && !legacy_irq_o && !mw_valid_o |-> ##[1:3] mw_valid_o)
        else $error("enabled event gave no message write");
    chk_msg_hold: assert property (
        mw_valid_o && !mw_ready_i |=> mw_valid_o && $stable(mw_addr_o)
        && $stable(mw_data_o) && $stable(mw_64_o))
        else $error("message write changed while stalled");
    chk_msg_form: assert property (
        mw_valid_o |-> mw_addr_o[1:0] == 2'b00 && mw_data_o[31:16] == 16'h0
        && mw_64_o == (mw_addr_o[63:32] != 32'h0))
        else $error("message write badly formed");
    chk_msg_done: assert property (
        mw_valid_o && mw_ready_i |=> !mw_valid_o)
        else $error("message write not retired");
    chk_table_hold: assert property (
        ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_addr_o)
        && $stable(ee_we_o)) else $error("table request dropped early");
    chk_table_release: assert property (
        ee_req_o && ee_ack_i |=> !ee_req_o) else $error("table request held");
endmodule

bind mvcr_bank mvcr_bank_sva #(.UPSTREAM(UPSTREAM), .PD_ADDR_W(PD_ADDR_W))
    i_mvcr_bank_sva (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .irq_event_i(irq_event_i), .legacy_irq_o(legacy_irq_o),
    .pm_next_ptr_o(pm_next_ptr_o), .mw_valid_o(mw_valid_o),
    .mw_addr_o(mw_addr_o), .mw_64_o(mw_64_o), .mw_data_o(mw_data_o),
    .mw_ready_i(mw_ready_i), .ee_req_o(ee_req_o), .ee_we_o(ee_we_o),
    .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i));

// >>> test/mvcr_ee_partner.sv
// EEPROM word store and message write sink with random latency
module mvcr_ee_partner (
    // Clock and reset
    input logic ref_clk_i,
    input logic sys_rst_i,
    // EEPROM word port
    input logic ee_req_i,
    input logic ee_we_i,
    input logic [5:0] ee_addr_i,
    input logic [31:0] ee_wdata_i,
    output logic ee_ack_o = 1'b0,
    output logic [31:0] ee_rdata_o = 32'h0,
    // Message write sink
    output logic mw_ready_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [64];
    int seed = 9;
    int lat = 3;
    int wait_cnt = 0;

    // ==========
    // Answer
    // Read data is only valid with ack; inverted after so stale use shows
    always @(posedge ref_clk_i)
    begin
        ee_ack_o <= 1'b0;
        mw_ready_o <= 1'($random(seed));
        if (ee_ack_o)
            ee_rdata_o <= ~ee_rdata_o;
        if (sys_rst_i || !ee_req_i || ee_ack_o)
            wait_cnt <= 0;
        else if (wait_cnt >= lat)
        begin
            ee_ack_o <= 1'b1;
            lat <= $unsigned($random(seed)) % 12;
            if (ee_we_i)
                mem[ee_addr_i] <= ee_wdata_i;
            else
                ee_rdata_o <= mem[ee_addr_i];
        end
        else
            wait_cnt <= wait_cnt + 1;
    end
endmodule

// >>> test/mvcr_bank_tb.sv
// Self-checking bench of the capability bank, downstream and upstream
module mvcr_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic up = 1'b0, cyc = 1'b0, we = 1'b0, irq_ev = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rd, r, lo, hi, em, mm, dat_dn, dat_up;
    logic ack_dn, ack_up, leg_dn, irq_dn, irq_up, mw_v, mw_rdy, mw_64;
    logic [63:0] mw_a;
    logic [31:0] mw_d, ee_wd, ee_rd;
    logic ee_req, ee_we, ee_ack;
    logic [5:0] ee_a, a;
    logic [31:0] exp_q[$], msk_q[$];
    logic [96:0] mw_q[$];
    int error_cnt = 0, cmp_count = 0, seed = 9, i, n;
    logic [40:0] rtab [13] = '{{1'b0, 8'h4C, 32'h00806405},
        {1'b0, 8'h50, 32'h0}, {1'b0, 8'h54, 32'h0}, {1'b0, 8'h58, 32'h0},
        {1'b0, 8'h5C, 32'h0}, {1'b0, 8'h64, 32'h0034B009},
        {1'b0, 8'h68, 32'h04001060}, {1'b0, 8'hFC, 32'h0},
        {1'b1, 8'h4C, 32'h0}, {1'b1, 8'h5C, 32'h00006403},
        {1'b1, 8'h60, 32'h0}, {1'b1, 8'h64, 32'h0034B009},
        {1'b1, 8'h68, 32'h04001060}};
    logic [71:0] wtab [5] = '{{8'h4C, 32'h00710000, 32'h00806405},
        {8'h50, 32'hFFFFFFFC, 32'h0}, {8'h54, 32'hFFFFFFFF, 32'h0},
        {8'h58, 32'h0000FFFF, 32'h0}, {8'h68, 32'hFFFFFFFF, 32'h0}};

    mvcr_bank #(.UPSTREAM(0)) i_mvcr_bank_dn (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc & !up), .wb_stb_i(cyc & !up),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_dn), .wb_ack_o(ack_dn), .irq_event_i(irq_ev),
        .legacy_irq_o(leg_dn), .pm_next_ptr_o(), .mw_valid_o(mw_v),
        .mw_addr_o(mw_a), .mw_64_o(mw_64), .mw_data_o(mw_d),
        .mw_ready_i(mw_rdy), .ee_req_o(), .ee_we_o(), .ee_addr_o(),
        .ee_wdata_o(), .ee_ack_i(ee_ack), .ee_rdata_i(ee_rd), .irq_o(irq_dn));
    mvcr_bank #(.UPSTREAM(1)) i_mvcr_bank_up (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc & up), .wb_stb_i(cyc & up),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_up), .wb_ack_o(ack_up), .irq_event_i(irq_ev),
        .legacy_irq_o(), .pm_next_ptr_o(), .mw_valid_o(), .mw_addr_o(),
        .mw_64_o(), .mw_data_o(), .mw_ready_i(mw_rdy), .ee_req_o(ee_req),
        .ee_we_o(ee_we), .ee_addr_o(ee_a), .ee_wdata_o(ee_wd),
        .ee_ack_i(ee_ack), .ee_rdata_i(ee_rd), .irq_o(irq_up));
    mvcr_ee_partner i_mvcr_ee_partner (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .ee_req_i(ee_req), .ee_we_i(ee_we),
        .ee_addr_i(ee_a), .ee_wdata_i(ee_wd), .ee_ack_o(ee_ack),
        .ee_rdata_o(ee_rd), .mw_ready_o(mw_rdy));

    // ==========
    // Tasks
    task automatic cmp(input logic [96:0] got, input logic [96:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time,
                got, exp);
        end
    endtask

    // Single classic cycle; a missing ack is cut short and counted
    task automatic wb(input logic p, input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        int k;
        k = 0;
        up <= p;
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        @(posedge ref_clk_i);
        while ((p ? ack_up : ack_dn) !== 1'b1 && k < 40)
        begin
            @(posedge ref_clk_i);
            k++;
        end
        if (k == 40)
            error_cnt++;
        cyc <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wb_rd(input logic p, input logic [7:0] ad,
        input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(p, 1'b0, ad, 32'h0);
    endtask

    task automatic poll(input logic want);
        int k;
        k = 0;
        do
        begin
            wb_rd(1'b1, 8'h5C, {8'h00, a, 18'h06403}, 32'h7FFFFFFF);
            k++;
        end
        while (rd[31] !== want && k < 60);
        if (k == 60)
            error_cnt++;
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========
    // Result monitor
    always @(posedge ref_clk_i)
    begin
        if (cyc && !we && (up ? ack_up : ack_dn))
        begin
            rd = up ? dat_up : dat_dn;
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            cmp(rd & mm, em & mm);
        end
        if (mw_v && mw_rdy)
        begin
            if (mw_q.size() == 0)
                cmp(1'b1, 1'b0);
            else
                cmp({mw_64, mw_a, mw_d}, mw_q.pop_front());
        end
    end

    initial
    begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        #100000;
        error_cnt++;
        finish_test;
    end

    // ==========
    // Sequence
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (i = 0; i < 13; i++)
            wb_rd(rtab[i][40], rtab[i][39:32], rtab[i][31:0], '1);
        for (i = 0; i < 5; i++)
        begin
            r = $random(seed);
            wb(1'b0, 1'b1, wtab[i][71:64], r);
            wb_rd(1'b0, wtab[i][71:64], r & wtab[i][63:32] | wtab[i][31:0],
                '1);
        end
        wb(1'b0, 1'b1, 8'h4C, 32'h0);
        irq_ev <= 1'b1;
        @(posedge ref_clk_i);
        cmp(leg_dn, 1'b1);
        irq_ev <= 1'b0;
        for (i = 0; i < 2; i++)
        begin
            hi = i ? 32'h0 : $random(seed);
            lo = $random(seed);
            r = $random(seed);
            wb(1'b0, 1'b1, 8'h54, hi);
            wb(1'b0, 1'b1, 8'h50, lo);
            wb(1'b0, 1'b1, 8'h58, r);
            wb(1'b0, 1'b1, 8'h4C, 32'h00010000);
            mw_q.push_back({|hi, hi, lo[31:2], 2'b00, 16'h0, r[15:0]});
            if (i)
                wb(1'b0, 1'b1, 8'hC8, 32'h1);
            else
            begin
                irq_ev <= 1'b1;
                @(posedge ref_clk_i);
                cmp(leg_dn, 1'b0);
                irq_ev <= 1'b0;
            end
            for (n = 0; n < 100 && mw_q.size() != 0; n++)
                @(posedge ref_clk_i);
            cmp(mw_q.size(), 0);
        end
        wb_rd(1'b0, 8'hC0, 32'h2, 32'h2);
        wb(1'b0, 1'b1, 8'hC4, 32'h0);
        cmp(irq_dn, 1'b0);
        wb(1'b0, 1'b1, 8'hC4, 32'h2);
        cmp(irq_dn, 1'b1);
        wb(1'b0, 1'b1, 8'hC0, 32'h2);
        cmp(irq_dn, 1'b0);
        // Partial lanes: low half of the test word lands, command refused
        sel <= 4'h3;
        wb(1'b1, 1'b1, 8'h68, '1);
        wb(1'b1, 1'b1, 8'h5C, 32'h80FC0000);
        sel <= 4'hF;
        wb_rd(1'b1, 8'h68, 32'h0400FFFF, '1);
        wb_rd(1'b1, 8'h5C, 32'h00006403, '1);
        wb(1'b1, 1'b1, 8'hC4, 32'h1);
        for (i = 0; i < 2; i++)
        begin
            a = i ? 6'h3F : 6'($random(seed));
            r = $random(seed);
            wb(1'b1, 1'b1, 8'h60, r);
            wb(1'b1, 1'b1, 8'h5C, {8'h80, a, 18'h0});
            poll(1'b0);
            cmp(i_mvcr_ee_partner.mem[a], r);
            cmp(irq_up, 1'b1);
            wb(1'b1, 1'b1, 8'hC0, 32'h1);
            cmp(irq_up, 1'b0);
            r = $random(seed);
            i_mvcr_ee_partner.mem[a] = r;
            wb(1'b1, 1'b1, 8'h5C, {8'h00, a, 18'h0});
            poll(1'b1);
            wb_rd(1'b1, 8'h60, r, '1);
            wb(1'b1, 1'b1, 8'hC0, 32'h1);
        end
        finish_test;
    end
endmodule
